// file: inc/phy_mgmt_defs.svh
// register offsets, field positions, reset values and frame counts
`ifndef PHY_MGMT_DEFS_SVH
`define PHY_MGMT_DEFS_SVH
`define REG_EVT_OFS     5'h1b
`define REG_DIAG_OFS    5'h1d
`define REG_CTL1_OFS    5'h1e
`define REG_CTL2_OFS    5'h1f
`define EVT_EN_LSB      8
`define DIAG_RUN_BIT    15
`define DIAG_RES_LSB    13
`define DIAG_SHORT_BIT  12
`define DIAG_RSVD_LSB   9
`define CTL1_PAUSE_BIT  9
`define CTL1_LINK_BIT   8
`define CTL1_POL_BIT    7
`define CTL2_IPOL_BIT   9
`define EVT_EN_RST      8'h00
`define EVT_FLAG_RST    8'h00
`define DIAG_RES_RST    2'h0
`define DIAG_RSVD_RST   3'h0
`define DIAG_DIST_RST   9'h000
`define IPOL_RST        1'b0
`define PRE_ONES        6'h20
`define HDR_BITS        5'h0e
`define DATA_BITS       5'h10
`define ST_CODE         2'h1
`define OP_RD           2'h2
`define OP_WR           2'h1
`endif

// file: inc/phy_mgmt_pkg.sv
// types shared by the management engine and the register bank
package phy_mgmt_pkg;
  // serial frame phases, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_HDR  = 4'b0010,
    S_TA   = 4'b0100,
    S_DATA = 4'b1000
  } mdio_state_t;
  typedef logic [15:0] reg_word_t;
endpackage : phy_mgmt_pkg

// file: inc/mgmt_reg_if.sv
// register access strobes between frame engine and register bank
`timescale 1ns/1ps
interface mgmt_reg_if;
  import phy_mgmt_pkg::*;
  logic       rd_stb;  // one-cycle read strobe
  logic       wr_stb;  // one-cycle write strobe
  logic [4:0] addr;    // register number
  reg_word_t  wdata;   // write word
  reg_word_t  rdata;   // read word, valid with rd_stb
  modport engine (output rd_stb, wr_stb, addr, wdata, input rdata);
  modport bank   (input rd_stb, wr_stb, addr, wdata, output rdata);
endinterface : mgmt_reg_if

// file: rtl/mdio_frame.sv
// serial management frame engine: preamble, header, turnaround, data
`timescale 1ns/1ps
`include "phy_mgmt_defs.svh"
module mdio_frame
  import phy_mgmt_pkg::*;
(
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  // management pins
  input  wire logic       i_mdc,
  input  wire logic       i_mdio,
  input  wire logic [4:0] i_phy_addr,
  output logic            o_mdio,
  output logic            o_mdio_oe,
  // register access
  mgmt_reg_if.engine      bus
);
  logic        mdc_meta, mdc_sync, mdc_prev;   // clock pin synchroniser
  logic        mdio_meta, mdio_sync;           // data pin synchroniser
  logic [4:0]  pa_meta, pa_sync;               // address strap synchroniser
  mdio_state_t state_reg;                      // frame phase
  logic [4:0]  cnt_reg;                        // bit counter in phase
  logic [5:0]  pre_reg;                        // consecutive preamble ones
  logic [15:0] shift_reg;                      // incoming bits
  logic [15:0] tx_reg;                         // outgoing read word
  logic        is_rd_reg;                      // frame is a read
  logic        rd_reg, wr_reg;                 // access strobes
  logic [4:0]  addr_reg;                       // register number
  logic [15:0] wdata_reg;                      // write word
  logic        out_reg, oe_reg;                // pin drive
  logic        mdc_rise, hdr_last, frame_ok;
  logic [13:0] hdr;

  // pins come from another clock: two flops before any use
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mdc_meta  <= 1'b0;
      mdc_sync  <= 1'b0;
      mdc_prev  <= 1'b0;
      mdio_meta <= 1'b1;
      mdio_sync <= 1'b1;
      pa_meta   <= 5'h00;
      pa_sync   <= 5'h00;
    end else begin
      mdc_meta  <= i_mdc;
      mdc_sync  <= mdc_meta;
      mdc_prev  <= mdc_sync;
      mdio_meta <= i_mdio;
      mdio_sync <= mdio_meta;
      pa_meta   <= i_phy_addr;
      pa_sync   <= pa_meta;
    end
  end

  // header check: start code, known opcode, our address
  assign mdc_rise = mdc_sync & ~mdc_prev;
  assign hdr      = {shift_reg[12:0], mdio_sync};
  assign hdr_last = (state_reg == S_HDR) && (cnt_reg == `HDR_BITS - 5'h01);
  assign frame_ok = (hdr[13:12] == `ST_CODE) && (hdr[9:5] == pa_sync) &&
                    ((hdr[11:10] == `OP_RD) || (hdr[11:10] == `OP_WR));

  // frame sequencer, advanced on each management clock rise
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 5'h00;
      pre_reg   <= 6'h00;
      shift_reg <= 16'h0000;
      is_rd_reg <= 1'b0;
    end else if (mdc_rise) begin
      shift_reg <= {shift_reg[14:0], mdio_sync};
      case (state_reg)
        S_IDLE: begin
          // a frame needs a full preamble before its start code
          if (mdio_sync) begin
            pre_reg <= (pre_reg == `PRE_ONES) ? pre_reg : pre_reg + 6'h01;
          end else begin
            pre_reg   <= 6'h00;
            shift_reg <= 16'h0000;
            if (pre_reg == `PRE_ONES) begin
              state_reg <= S_HDR;
              cnt_reg   <= 5'h01;
            end
          end
        end
        S_HDR: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (hdr_last) begin
            // foreign or malformed frames fall back to preamble hunt
            cnt_reg   <= 5'h00;
            is_rd_reg <= (hdr[11:10] == `OP_RD);
            state_reg <= frame_ok ? S_TA : S_IDLE;
          end
        end
        S_TA: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == 5'h01) begin
            cnt_reg   <= 5'h00;
            state_reg <= S_DATA;
          end
        end
        S_DATA: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == `DATA_BITS - 5'h01) begin
            cnt_reg   <= 5'h00;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // register access strobes, one core cycle each
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      addr_reg  <= 5'h00;
      wdata_reg <= 16'h0000;
    end else begin
      rd_reg <= mdc_rise && hdr_last && frame_ok && (hdr[11:10] == `OP_RD);
      wr_reg <= mdc_rise && (state_reg == S_DATA) && !is_rd_reg &&
                (cnt_reg == `DATA_BITS - 5'h01);
      if (mdc_rise && hdr_last) begin
        addr_reg <= hdr[4:0];
      end
      if (mdc_rise && (state_reg == S_DATA)) begin
        wdata_reg <= {shift_reg[14:0], mdio_sync};
      end
    end
  end

  // read data out: zero in second turnaround bit, then msb first
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_reg  <= 16'h0000;
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else if (rd_reg) begin
      tx_reg <= bus.rdata;
    end else if (mdc_rise && is_rd_reg) begin
      if (state_reg == S_TA) begin
        oe_reg  <= 1'b1;
        out_reg <= (cnt_reg == 5'h01) ? tx_reg[15] : 1'b0;
        if (cnt_reg == 5'h01) begin
          tx_reg <= {tx_reg[14:0], 1'b0};
        end
      end else if (state_reg == S_DATA) begin
        // release the line while the last bit is sampled
        oe_reg  <= (cnt_reg != `DATA_BITS - 5'h01);
        out_reg <= (cnt_reg != `DATA_BITS - 5'h01) & tx_reg[15];
        tx_reg  <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  assign bus.rd_stb = rd_reg;
  assign bus.wr_stb = wr_reg;
  assign bus.addr   = addr_reg;
  assign bus.wdata  = wdata_reg;
  assign o_mdio     = out_reg;
  assign o_mdio_oe  = oe_reg;
endmodule : mdio_frame

// file: rtl/phy_event_flags_cable_diag_status.sv
// event flags, cable diagnostic and phy control status registers
`timescale 1ns/1ps
`include "phy_mgmt_defs.svh"
module phy_event_flags_cable_diag_status
  import phy_mgmt_pkg::*;
(
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  // management pins
  input  wire logic       i_mdc,
  input  wire logic       i_mdio,
  input  wire logic [4:0] i_phy_addr,
  output logic            o_mdio,
  output logic            o_mdio_oe,
  // event pulses from phy core
  input  wire logic       i_evt_jabber,
  input  wire logic       i_evt_rx_err,
  input  wire logic       i_evt_page_rx,
  input  wire logic       i_evt_pd_fault,
  input  wire logic       i_evt_lp_ack,
  input  wire logic       i_evt_remote_fault,
  // live status from phy core
  input  wire logic       i_link_up,
  input  wire logic       i_pause_cap,
  input  wire logic       i_pol_reversed,
  // cable diagnostic engine
  input  wire logic       i_diag_done,
  input  wire logic [1:0] i_diag_result,
  input  wire logic       i_diag_short,
  input  wire logic [8:0] i_diag_distance,
  output logic            o_diag_run,
  // interrupt pin
  output logic            o_intr
);
  mgmt_reg_if rif ();                    // engine to bank strobes

  logic [7:0] ien_reg;                   // per-flag enables
  logic [7:0] flag_reg;                  // sticky event flags
  logic [7:0] flag_next;
  logic [7:0] evt;                       // this cycle's events
  logic       link_reg;                  // registered link state
  logic       pause_reg;                 // registered pause capability
  logic       pol_reg;                   // registered polarity state
  logic       diag_run_reg;              // test running
  logic [1:0] diag_res_reg;              // outcome code
  logic       diag_short_reg;            // short cable seen
  logic [2:0] diag_rsvd_reg;             // spare read-write bits
  logic [8:0] diag_dist_reg;             // distance to fault
  logic       ipol_reg;                  // 1 = interrupt active high
  logic       intr_reg;                  // interrupt pin level
  logic       any_pend;                  // enabled flag pending
  logic       rd_evt, wr_evt, wr_diag, wr_ctl2;
  reg_word_t  rdata;

  // register number compare, shared by all decodes
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // serial frame engine
  mdio_frame u_frame (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_mdc      (i_mdc),
    .i_mdio     (i_mdio),
    .i_phy_addr (i_phy_addr),
    .o_mdio     (o_mdio),
    .o_mdio_oe  (o_mdio_oe),
    .bus        (rif.engine)
  );

  // access decodes
  assign rd_evt  = rif.rd_stb && hit(rif.addr, `REG_EVT_OFS);
  assign wr_evt  = rif.wr_stb && hit(rif.addr, `REG_EVT_OFS);
  assign wr_diag = rif.wr_stb && hit(rif.addr, `REG_DIAG_OFS);
  assign wr_ctl2 = rif.wr_stb && hit(rif.addr, `REG_CTL2_OFS);

  // live status sampled so reset shows zero
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      link_reg  <= 1'b0;
      pause_reg <= 1'b0;
      pol_reg   <= 1'b0;
    end else begin
      link_reg  <= i_link_up;
      pause_reg <= i_pause_cap;
      pol_reg   <= i_pol_reversed;
    end
  end

  // event vector in flag bit order; link edges come from link state
  // link loss edge
  assign evt = {i_evt_jabber, i_evt_rx_err, i_evt_page_rx, i_evt_pd_fault,
                i_evt_lp_ack, link_reg & ~i_link_up, i_evt_remote_fault,
                i_link_up & ~link_reg};

  // read clears, but a same-cycle event wins so none is lost
  // flags set, read clears
  always_comb begin
    flag_next = rd_evt ? 8'h00 : flag_reg;
    flag_next = flag_next | evt;
  end

  // sticky flags
  // page flag stored
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_reg <= `EVT_FLAG_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // enables; the low byte of a write is ignored, flags are read-only
  // link-up enable bit
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ien_reg <= `EVT_EN_RST;
    end else if (wr_evt) begin
      ien_reg <= rif.wdata[`EVT_EN_LSB +: 8];
    end
  end

  // diagnostic launch and completion
  // run bit self-clears
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      diag_run_reg <= 1'b0;
    end else if (wr_diag) begin
      // a write wins over completion so a relaunch is never dropped
      diag_run_reg <= rif.wdata[`DIAG_RUN_BIT];
    end else if (i_diag_done) begin
      diag_run_reg <= 1'b0;
    end
  end

  // results captured only at the end of a run, stable otherwise
  // outcome code captured
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      diag_res_reg   <= `DIAG_RES_RST;
      diag_short_reg <= 1'b0;
      diag_dist_reg  <= `DIAG_DIST_RST;
    end else if (diag_run_reg && i_diag_done) begin
      diag_res_reg   <= i_diag_result;
      diag_short_reg <= i_diag_short;
      diag_dist_reg  <= i_diag_distance;
    end
  end

  // spare read-write bits of the diagnostic register
  // reserved bits writable
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      diag_rsvd_reg <= `DIAG_RSVD_RST;
    end else if (wr_diag) begin
      diag_rsvd_reg <= rif.wdata[`DIAG_RSVD_LSB +: 3];
    end
  end

  // interrupt polarity control; other bits of that register not kept
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ipol_reg <= `IPOL_RST;
    end else if (wr_ctl2) begin
      ipol_reg <= rif.wdata[`CTL2_IPOL_BIT];
    end
  end

  // interrupt pin, registered so it never glitches
  // held while pending
  assign any_pend = |(flag_reg & ien_reg);
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      intr_reg <= 1'b1;
    end else begin
      intr_reg <= ipol_reg ? any_pend : ~any_pend;
    end
  end

  // read word mux; unknown registers read zero
  // pause status bit
  always_comb begin
    rdata = 16'h0000;
    case (rif.addr)
      `REG_EVT_OFS: begin
        rdata = {ien_reg, flag_reg};
      end
      `REG_DIAG_OFS: begin
        rdata = {diag_run_reg, diag_res_reg, diag_short_reg,
                 diag_rsvd_reg, diag_dist_reg};
      end
      `REG_CTL1_OFS: begin
        rdata[`CTL1_PAUSE_BIT] = pause_reg;
        rdata[`CTL1_LINK_BIT]  = link_reg;
        rdata[`CTL1_POL_BIT]   = pol_reg;
      end
      `REG_CTL2_OFS: begin
        rdata[`CTL2_IPOL_BIT] = ipol_reg;
      end
      default: rdata = 16'h0000;
    endcase
  end
  assign rif.rdata = rdata;

  // results only valid once the run bit reads back zero
  // run bit shown
  assign o_diag_run = diag_run_reg;
  assign o_intr     = intr_reg;

  // ---- checks ----
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_launch;
    wr_diag && rif.wdata[`DIAG_RUN_BIT];
  endsequence
  sequence s_finish;
    diag_run_reg && i_diag_done && !wr_diag;
  endsequence

  a_enable_write: assert property (
    wr_evt |=> ien_reg == $past(rif.wdata[15:8]))
    else $error("enable byte not taken from write");
  a_flag_set: assert property (
    (|evt) |=> ((flag_reg & $past(evt)) == $past(evt)))
    else $error("event did not set its flag");
  a_flag_clear: assert property (
    (rd_evt && evt == 8'h00) |=> flag_reg == 8'h00)
    else $error("read did not clear flags");
  a_flag_hold: assert property (
    (!rd_evt && evt == 8'h00) |=> flag_reg == $past(flag_reg))
    else $error("flag changed without cause");
  a_diag_launch: assert property (
    s_launch |=> diag_run_reg ##0 o_diag_run)
    else $error("diagnostic run not started");
  a_diag_finish: assert property (
    s_finish |=> !diag_run_reg && diag_res_reg == $past(i_diag_result)
                 && diag_dist_reg == $past(i_diag_distance))
    else $error("diagnostic completion not captured");
  a_intr_level: assert property (
    ##1 o_intr == ($past(ipol_reg) ~^ |($past(flag_reg) & $past(ien_reg))))
    else $error("interrupt pin level wrong");
  a_ctl1_status: assert property (
    hit(rif.addr, `REG_CTL1_OFS) |-> rdata[8] == link_reg && rdata[15:10] == 6'h00
                                     && rdata[9] == pause_reg && rdata[7] == pol_reg)
    else $error("control status read wrong");
endmodule : phy_event_flags_cable_diag_status

// file: verif/mdio_master_model.sv
// station management controller model driving serial frames on mdc/mdio
`timescale 1ns/1ps
`include "phy_mgmt_defs.svh"
module mdio_master_model
  import phy_mgmt_pkg::*;
(
  // clock
  input  wire logic i_core_clk,
  // management pins
  input  wire logic i_mdio,
  output logic      o_mdc,
  output logic      o_mdio,
  output logic      o_mdio_oe
);
  localparam int HALF = 5;  // mdc half period in core cycles, above the 4 minimum

  // mdc stands low and the line is released outside frames
  initial begin
    o_mdc     = 1'b0;
    o_mdio    = 1'b1;
    o_mdio_oe = 1'b0;
  end

  // one mdc period: drive on the low phase, sample the line at the rise
  task automatic bit_cycle(input logic en, input logic b, output logic s);
    @(posedge i_core_clk);
    o_mdio_oe <= en;
    o_mdio    <= b;
    o_mdc     <= 1'b0;
    repeat (HALF) @(posedge i_core_clk);
    s = i_mdio;
    o_mdc <= 1'b1;
    repeat (HALF - 1) @(posedge i_core_clk);
  endtask : bit_cycle

  // whole frame, fresh preamble each time
  task automatic frame(input logic [4:0] phy, input logic [4:0] rg, input logic wr,
                       input reg_word_t wd, output reg_word_t rd);
    logic [13:0] hdr;  // start, op, phy address, register
    logic        s;    // sampled line level
    hdr = {`ST_CODE, (wr ? `OP_WR : `OP_RD), phy, rg};
    rd  = '0;
    repeat (`PRE_ONES) bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    // turnaround: a write drives 1 then 0, a read lets the device take the line
    bit_cycle(wr, 1'b1, s);
    bit_cycle(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(wr, wd[i], s);
      rd[i] = s;
    end
    @(posedge i_core_clk);
    o_mdio_oe <= 1'b0;
    o_mdc     <= 1'b0;
    // gap lets a write land before the next frame
    repeat (8) @(posedge i_core_clk);
  endtask : frame
endmodule : mdio_master_model

// file: verif/tb.sv
// self-checking bench for the event flag, cable diagnostic and status registers
`timescale 1ns/1ps
`include "phy_mgmt_defs.svh"
module tb
  import phy_mgmt_pkg::*;
;
  typedef struct packed {
    logic [5:0] ev;    // jabber, rx err, page, pd fault, lp ack, remote fault
    logic       link;  // link level applied with the pulse
    reg_word_t  exp;   // expected event register word
  } row_t;

  logic       clk = 1'b0;  // core clock, 5 ns
  logic       rstn;        // active low reset
  logic [5:0] ev;          // event pulses
  logic       link, pause, pol;
  logic       diag_done, diag_short;
  logic [1:0] diag_res;
  logic [8:0] diag_dist;
  logic       mdc, m_mdio, m_oe, d_mdio, d_oe, diag_run, intr;
  wire        line;        // resolved mdio wire, pulled up when idle
  int         n_errors = 0;
  int         check_count = 0;
  reg_word_t  v;
  row_t rows [10] = '{'{6'h20, 1'b0, 16'h0080}, '{6'h10, 1'b0, 16'h0040},
                      '{6'h08, 1'b0, 16'h0020}, '{6'h04, 1'b0, 16'h0010},
                      '{6'h02, 1'b0, 16'h0008}, '{6'h01, 1'b0, 16'h0002},
                      '{6'h00, 1'b1, 16'h0001}, '{6'h00, 1'b0, 16'h0004},
                      '{6'h3f, 1'b1, 16'h00fb}, '{6'h00, 1'b0, 16'h0004}};

  assign line = d_oe ? d_mdio : (m_oe ? m_mdio : 1'b1);

  always #2.5 clk = ~clk;

  phy_event_flags_cable_diag_status u_dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_mdc(mdc), .i_mdio(line), .i_phy_addr(5'h03),
    .o_mdio(d_mdio), .o_mdio_oe(d_oe), .i_evt_jabber(ev[5]), .i_evt_rx_err(ev[4]),
    .i_evt_page_rx(ev[3]), .i_evt_pd_fault(ev[2]), .i_evt_lp_ack(ev[1]),
    .i_evt_remote_fault(ev[0]), .i_link_up(link), .i_pause_cap(pause),
    .i_pol_reversed(pol), .i_diag_done(diag_done), .i_diag_result(diag_res),
    .i_diag_short(diag_short), .i_diag_distance(diag_dist), .o_diag_run(diag_run),
    .o_intr(intr));

  mdio_master_model u_mdm (
    .i_core_clk(clk), .i_mdio(line), .o_mdc(mdc), .o_mdio(m_mdio), .o_mdio_oe(m_oe));

  // compare and count
  task automatic chk(input reg_word_t seen, input reg_word_t exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic wr(input logic [4:0] rg, input reg_word_t d);
    u_mdm.frame(5'h03, rg, 1'b1, d, v);
  endtask : wr

  // read and compare; the caller's line names what is compared
  task automatic rd_chk(input logic [4:0] rg, input reg_word_t exp);
    u_mdm.frame(5'h03, rg, 1'b0, '0, v);
    chk(v, exp);
  endtask : rd_chk

  // one-cycle event pulse, then let flag and pin settle
  task automatic pulse(input logic [5:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
    repeat (3) @(posedge clk);
  endtask : pulse

  // hang guard, well beyond the ~50 frames of the run
  initial begin
    #400us;
    n_errors++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    ev = 6'h00;
    {link, pause, pol, diag_done, diag_short, diag_res, diag_dist} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    // reset values
    chk({15'h0, intr}, 16'h0001);
    chk({15'h0, diag_run}, 16'h0000);
    rd_chk(`REG_EVT_OFS, 16'h0000);
    rd_chk(`REG_DIAG_OFS, 16'h0000);
    rd_chk(`REG_CTL1_OFS, 16'h0000);
    // table: each flag sets, then clears after one read
    foreach (rows[i]) begin
      link <= rows[i].link;
      pulse(rows[i].ev);
      rd_chk(`REG_EVT_OFS, rows[i].exp);
      rd_chk(`REG_EVT_OFS, 16'h0000);
    end
    // live status bits, writes to them ignored
    {pause, pol, link} <= 3'b111;
    wr(`REG_CTL1_OFS, 16'hffff);
    rd_chk(`REG_CTL1_OFS, 16'h0380);
    {pause, pol, link} <= 3'b010;
    repeat (3) @(posedge clk);
    rd_chk(`REG_CTL1_OFS, 16'h0080);
    rd_chk(`REG_EVT_OFS, 16'h0005);
    // enables are read-write, flags ignore writes
    wr(`REG_EVT_OFS, 16'hffff);
    rd_chk(`REG_EVT_OFS, 16'hff00);
    pulse(6'h20);
    chk({15'h0, intr}, 16'h0000);
    rd_chk(`REG_EVT_OFS, 16'hff80);
    chk({15'h0, intr}, 16'h0001);
    // active-high polarity flips the idle level
    wr(`REG_CTL2_OFS, 16'h0200);
    chk({15'h0, intr}, 16'h0000);
    pulse(6'h10);
    chk({15'h0, intr}, 16'h0001);
    rd_chk(`REG_EVT_OFS, 16'hff40);
    // only link-up enabled: other events stay silent on the pin
    wr(`REG_EVT_OFS, 16'h0100);
    pulse(6'h3f);
    chk({15'h0, intr}, 16'h0000);
    link <= 1'b1;
    repeat (4) @(posedge clk);
    chk({15'h0, intr}, 16'h0001);
    rd_chk(`REG_EVT_OFS, 16'h01fb);
    chk({15'h0, intr}, 16'h0000);
    // every result code; inputs scrambled after done to prove capture
    for (int r = 0; r < 4; r++) begin
      wr(`REG_DIAG_OFS, 16'h8000);
      chk({15'h0, diag_run}, 16'h0001);
      @(posedge clk);
      {diag_res, diag_short, diag_dist} <= {r[1:0], r[0], 9'h100 + 9'(r)};
      diag_done <= 1'b1;
      @(posedge clk);
      diag_done <= 1'b0;
      {diag_res, diag_short, diag_dist} <= '1;
      repeat (3) @(posedge clk);
      chk({15'h0, diag_run}, 16'h0000);
      // results read only once the run bit is back low
      rd_chk(`REG_DIAG_OFS, {1'b0, r[1:0], r[0], 3'h0, 9'h100 + 9'(r)});
    end
    // reserved bits hold writes, result fields do not; a zero write aborts
    wr(`REG_DIAG_OFS, 16'h8e00);
    rd_chk(`REG_DIAG_OFS, 16'hff03);
    wr(`REG_DIAG_OFS, 16'h0000);
    chk({15'h0, diag_run}, 16'h0000);
    // a stray done while idle must not capture the scrambled inputs
    @(posedge clk);
    diag_done <= 1'b1;
    @(posedge clk);
    diag_done <= 1'b0;
    rd_chk(`REG_DIAG_OFS, 16'h7103);
    // unmapped register reads zero; a foreign frame leaves flags alone
    rd_chk(5'h05, 16'h0000);
    link <= 1'b0;
    repeat (3) @(posedge clk);
    u_mdm.frame(5'h04, `REG_EVT_OFS, 1'b0, '0, v);
    chk(v, 16'hffff);
    rd_chk(`REG_EVT_OFS, 16'h0104);
    // reset in mid-run drops pending flags and polarity
    pulse(6'h20);
    chk({15'h0, intr}, 16'h0000);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({15'h0, intr}, 16'h0001);
    rd_chk(`REG_EVT_OFS, 16'h0000);
    rd_chk(`REG_CTL2_OFS, 16'h0000);
    conclude();
  end
endmodule : tb
